// [hdl/tas_acquisition_sequencer.sv]
// Touch acquisition sequencer: modes, pen detection, channel bias, conversions and status events.
// Assumes commands and reads come from a serial engine on the same clock; the pen comparator is a pin.
// Overview of operation
// - Order 0 passes each sample; order 1 outputs mean of three scaled 4079/4095.
// - Order 2 outputs the mean of five consecutive samples scaled 4079/4095.
// - Order 3 tracks two extremes each side of seven samples, drops them, averages middle three.
// - Programmable settle delay separates repeated conversions of one channel, minimum half microsecond.
// - Bias and settle delays span half a microsecond to about eighteen milliseconds.
// - After reset the block is in manual mode with acquisition stopped.
// - Manual mode converts only on convert commands, then idles.
// - Manual convert runs a pen check first, skips without pen, never updates pen flag.
// - Single-channel convert biases the channel, waits bias delay, then converts.
// - Sequence convert walks enabled channels: bias, convert, remove bias automatically.
// - Select only biases the named channel; host never selects the sequence selector.
// - A convert following select converts without any pen detection.
// - Completion clears busy flag, lowers irq if unmasked, released once data is read.
// - Pen-watch mode only detects pen: continuously when up, once per tick when down.
// - Pen-watch holds detection while irq is low; such ticks are dropped.
// - Pen-trigger mode detects pen and converts enabled channels when down, raising events.
// - Pen-trigger skips any tick while converted data of enabled channels remain unread.
// - Conversion time is 47 periods plus per channel bias, settles and 21N+1 periods.
// - Touch sets the pen flag, release clears it, each raising an unmasked interrupt.
// - Pen detection biases for one eighth of the bias delay before sampling.
`timescale 1ns/1ns
module tas_acquisition_sequencer
  import tas_pkg::*;
#(
  parameter int TICK_UNIT = TICK_UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Host commands
  input  wire logic              cmd_valid,
  input  wire tas_cmd_e          cmd_code,
  input  wire logic [CH_W-1:0]   cmd_channel,
  // Configuration
  input  wire logic [7:0]        touch_tick_rate,
  input  wire logic [1:0]        filter_order,
  input  wire logic [15:0]       bias_delay,
  input  wire logic [15:0]       inter_sample_delay,
  input  wire logic [NCHAN-1:0]  channel_enable_mask,
  input  wire logic [IRQ_W-1:0]  interrupt_mask,
  // Host reads
  input  wire logic              data_read,
  input  wire logic [CH_W-1:0]   data_read_channel,
  input  wire logic              irq_source_read,
  // Analog side
  input  wire logic              pen_comparator,
  output logic [NCHAN-1:0]       ch_bias,
  output logic                   pen_bias_en,
  output logic                   adc_start,
  output logic [CH_W-1:0]        adc_channel,
  input  wire logic [SMP_W-1:0]  adc_data,
  // Results and status
  output logic                   result_valid,
  output logic [CH_W-1:0]        result_channel,
  output logic [SMP_W-1:0]       result_data,
  output logic                   conversion_busy_flag,
  output logic                   pen_down_flag,
  output logic [IRQ_W-1:0]       interrupt_source,
  output logic                   irq_n
);

  if (TICK_UNIT < 1) begin : g_bad_tick
    $error("TICK_UNIT must be at least one cycle.");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_PEN_BIAS, S_WAIT_TICK, S_OVERHEAD, S_CH_BIAS, S_SAMPLE, S_SETTLE, S_FILTER
  } tas_state_e;

  typedef struct packed {
    logic             pen_s1;
    logic             pen_s2;
    tas_mode_e        mode;
    tas_state_e       st;
    logic [DLY_W-1:0] cnt;
    logic [31:0]      tick_cnt;
    logic [NCHAN-1:0] pend;
    logic [CH_W-1:0]  cur_ch;
    logic [CH_W-1:0]  res_ch;
    logic [2:0]       left;
    logic             last;
    logic             sel_valid;
    logic [NCHAN-1:0] bias;
    logic             pen_bias;
    logic             adc_start;
    logic             busy;
    logic             pen_down;
    logic [NCHAN-1:0] unread;
    logic [IRQ_W-1:0] src;
    logic             irq_n;
  } tas_seq_s;

  tas_seq_s q_reg;
  tas_seq_s q_next;

  // Delays are in half-microsecond units; zero and over-range codes are clamped into range.
  function automatic logic [DLY_W-1:0] dly_cycles(input logic [15:0] units);
    logic [31:0] u;
    u = 32'(units);
    if (u == 32'h0) u = 32'h1;
    if (u > 32'(DLY_MAX_UNITS)) u = 32'(DLY_MAX_UNITS);
    return DLY_W'(u * 32'(HALF_US_CYCLES) - 32'h1);
  endfunction : dly_cycles

  function automatic logic [NCHAN-1:0] ch_bit(input logic [CH_W-1:0] ch);
    return NCHAN'(1) << ch;
  endfunction : ch_bit

  function automatic logic [CH_W-1:0] first_ch(input logic [NCHAN-1:0] m);
    logic [CH_W-1:0] r;
    r = '0;
    for (int i = NCHAN - 1; i >= 0; i--) begin
      if (m[i]) r = CH_W'(i);
    end
    return r;
  endfunction : first_ch

  logic [31:0]      tick_period;
  logic             tick;
  logic             filt_clear;
  logic             filt_sample;
  logic             filt_finish;
  logic             filt_valid;
  logic [SMP_W-1:0] filt_data;

  assign tick_period = 32'(touch_tick_rate) * 32'(TICK_UNIT);
  assign tick = (q_reg.mode != MODE_MANUAL) && (touch_tick_rate != 8'h00) && (q_reg.tick_cnt >= tick_period - 32'h1);
  assign filt_sample = (q_reg.st == S_SAMPLE) && (q_reg.cnt == '0);
  assign filt_finish = (q_reg.st == S_FILTER);

  always_comb begin
    logic             start_conv;
    logic             begin_ch;
    logic             start_pen;
    logic             pen;
    logic             changed;
    logic [NCHAN-1:0] rd_clr;
    logic [NCHAN-1:0] rest;
    logic [IRQ_W-1:0] src_set;
    logic [IRQ_W-1:0] src_clr;
    start_conv = 1'b0;
    begin_ch = 1'b0;
    start_pen = 1'b0;
    pen = q_reg.pen_s2;
    changed = pen != q_reg.pen_down;
    rd_clr = data_read ? ch_bit(data_read_channel) : '0;
    rest = q_reg.pend & ~ch_bit(q_reg.cur_ch);
    src_set = '0;
    src_clr = '0;
    filt_clear = 1'b0;
    q_next = q_reg;
    q_next.pen_s1 = pen_comparator;
    q_next.pen_s2 = q_reg.pen_s1;
    q_next.adc_start = 1'b0;
    q_next.tick_cnt = (tick || q_reg.mode == MODE_MANUAL) ? 32'h0 : q_reg.tick_cnt + 32'h1;
    if (result_valid && q_reg.last) begin
      q_next.busy = 1'b0;
      src_set[IRQ_CONV] = 1'b1;
    end
    unique case (q_reg.st)
      S_IDLE: begin
        if (cmd_valid && q_reg.mode == MODE_MANUAL && cmd_code == CMD_SELECT && cmd_channel < CH_W'(NCHAN)) begin
          q_next.bias = ch_bit(cmd_channel);
          q_next.cur_ch = cmd_channel;
          q_next.sel_valid = 1'b1;
        end else if (cmd_valid && q_reg.mode == MODE_MANUAL && cmd_code == CMD_CONVERT) begin
          q_next.pend = (cmd_channel == SEQ_ALL_SEL) ? channel_enable_mask : ch_bit(cmd_channel);
          if (q_reg.sel_valid) start_conv = 1'b1;
          else start_pen = 1'b1;
        end
      end
      S_PEN_BIAS: begin
        if (q_reg.cnt == '0) begin
          q_next.pen_bias = 1'b0;
          if (q_reg.mode == MODE_MANUAL) begin
            if (pen && q_reg.pend != '0) start_conv = 1'b1;
            else begin
              q_next.st = S_IDLE;
              q_next.pend = '0;
            end
          end else begin
            if (changed) begin
              q_next.pen_down = pen;
              src_set[IRQ_TOUCH] = pen;
              src_set[IRQ_RELEASE] = !pen;
            end
            if (q_reg.mode == MODE_PEN_TRIGGER && pen) begin
              q_next.pend = channel_enable_mask;
              start_conv = 1'b1;
            end else if (pen || !q_reg.irq_n || (changed && interrupt_mask[IRQ_RELEASE])) begin
              q_next.st = S_WAIT_TICK;
            end else begin
              start_pen = 1'b1;
            end
          end
        end else begin
          q_next.cnt = q_reg.cnt - DLY_W'(1);
        end
      end
      S_WAIT_TICK: begin
        if (tick) begin
          if (q_reg.mode == MODE_PEN_WATCH && !q_reg.irq_n) q_next.st = S_WAIT_TICK;
          else if (q_reg.mode == MODE_PEN_TRIGGER && q_reg.unread != '0) q_next.st = S_WAIT_TICK;
          else start_pen = 1'b1;
        end
      end
      S_OVERHEAD: begin
        if (q_reg.cnt != '0) q_next.cnt = q_reg.cnt - DLY_W'(1);
        else if (q_reg.pend != '0) begin_ch = 1'b1;
        else begin
          q_next.busy = 1'b0;
          q_next.st = (q_reg.mode == MODE_PEN_TRIGGER) ? S_WAIT_TICK : S_IDLE;
        end
      end
      S_CH_BIAS: begin
        if (q_reg.cnt != '0) q_next.cnt = q_reg.cnt - DLY_W'(1);
        else begin
          q_next.adc_start = 1'b1;
          q_next.st = S_SAMPLE;
          q_next.cnt = DLY_W'(SAMPLE_CYCLES - 1);
          q_next.left = {filter_order, 1'b0};
        end
      end
      S_SAMPLE: begin
        if (q_reg.cnt != '0) q_next.cnt = q_reg.cnt - DLY_W'(1);
        else if (q_reg.left == 3'h0) begin
          q_next.st = S_FILTER;
          q_next.bias = '0;
        end else begin
          q_next.st = S_SETTLE;
          q_next.cnt = dly_cycles(inter_sample_delay);
        end
      end
      S_SETTLE: begin
        if (q_reg.cnt != '0) q_next.cnt = q_reg.cnt - DLY_W'(1);
        else begin
          q_next.adc_start = 1'b1;
          q_next.st = S_SAMPLE;
          q_next.cnt = DLY_W'(SAMPLE_CYCLES - 1);
          q_next.left = q_reg.left - 3'h1;
        end
      end
      S_FILTER: begin
        q_next.res_ch = q_reg.cur_ch;
        q_next.pend = rest;
        q_next.last = (rest == '0);
        if (rest != '0) begin_ch = 1'b1;
        else q_next.st = (q_reg.mode == MODE_PEN_TRIGGER) ? S_WAIT_TICK : S_IDLE;
      end
    endcase
    if (start_conv) begin
      q_next.st = S_OVERHEAD;
      q_next.cnt = DLY_W'(OVERHEAD_CYCLES - 1);
      q_next.busy = 1'b1;
      q_next.sel_valid = 1'b0;
      q_next.last = 1'b0;
    end
    if (begin_ch) begin
      q_next.cur_ch = first_ch(q_next.pend);
      q_next.bias = ch_bit(first_ch(q_next.pend));
      q_next.st = S_CH_BIAS;
      q_next.cnt = dly_cycles(bias_delay);
      filt_clear = 1'b1;
    end
    if (start_pen) begin
      q_next.st = S_PEN_BIAS;
      q_next.bias = '0;
      q_next.pen_bias = 1'b1;
      q_next.cnt = dly_cycles(bias_delay >> PEN_BIAS_SHIFT);
    end
    // A mode command aborts whatever is in flight and restarts; pen flag, unread flags and interrupt sources keep their values.
    if (cmd_valid && cmd_code inside {CMD_MANUAL, CMD_PEN_WATCH, CMD_PEN_TRIGGER}) begin
      q_next.bias = '0;
      q_next.pend = '0;
      q_next.busy = 1'b0;
      q_next.sel_valid = 1'b0;
      q_next.tick_cnt = 32'h0;
      q_next.adc_start = 1'b0;
      q_next.pen_bias = (cmd_code != CMD_MANUAL);
      q_next.cnt = dly_cycles(bias_delay >> PEN_BIAS_SHIFT);
      q_next.st = (cmd_code == CMD_MANUAL) ? S_IDLE : S_PEN_BIAS;
      unique case (cmd_code)
        CMD_PEN_WATCH:   q_next.mode = MODE_PEN_WATCH;
        CMD_PEN_TRIGGER: q_next.mode = MODE_PEN_TRIGGER;
        default:         q_next.mode = MODE_MANUAL;
      endcase
    end
    // A set arriving with a clear wins, since the clear is applied first.
    q_next.unread = (q_reg.unread & ~rd_clr) | (filt_valid ? ch_bit(q_reg.res_ch) : '0);
    src_clr[IRQ_CONV] = (q_reg.unread != '0) && ((q_reg.unread & ~rd_clr) == '0);
    src_clr[IRQ_TOUCH] = irq_source_read;
    src_clr[IRQ_RELEASE] = irq_source_read;
    q_next.src = (q_reg.src & ~src_clr) | src_set;
    q_next.irq_n = ~|(q_next.src & interrupt_mask);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q_reg <= '{pen_s1: 1'b0, pen_s2: 1'b0, mode: MODE_MANUAL, st: S_IDLE, cnt: '0, tick_cnt: 32'h0,
                 pend: '0, cur_ch: '0, res_ch: '0, left: 3'h0, last: 1'b0, sel_valid: 1'b0, bias: '0,
                 pen_bias: 1'b0, adc_start: 1'b0, busy: 1'b0, pen_down: 1'b0, unread: '0,
                 src: RST_IRQ_SRC, irq_n: 1'b1};
    end else begin
      q_reg <= q_next;
    end
  end

  tas_sample_filter u_filter (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .order        (filter_order),
    .clear        (filt_clear),
    .sample_valid (filt_sample),
    .sample_data  (adc_data),
    .finish       (filt_finish),
    .out_valid    (filt_valid),
    .out_data     (filt_data)
  );

  assign ch_bias              = q_reg.bias;
  assign pen_bias_en          = q_reg.pen_bias;
  assign adc_start            = q_reg.adc_start;
  assign adc_channel          = q_reg.cur_ch;
  assign result_valid         = filt_valid;
  assign result_channel       = q_reg.res_ch;
  assign result_data          = filt_data;
  assign conversion_busy_flag = q_reg.busy;
  assign pen_down_flag        = q_reg.pen_down;
  assign interrupt_source     = q_reg.src;
  assign irq_n                = q_reg.irq_n;

  property p_manual_pen_frozen;
    @(posedge clock) disable iff (sys_rst)
      q_reg.mode == MODE_MANUAL && $past(q_reg.mode) == MODE_MANUAL |-> $stable(pen_down_flag);
  endproperty
  a_manual_pen_frozen: assert property (p_manual_pen_frozen) else $error("Pen flag moved in manual mode.");

  property p_done_irq;
    @(posedge clock) disable iff (sys_rst)
      result_valid && q_reg.last && interrupt_mask[IRQ_CONV] && !cmd_valid |=> !irq_n && !conversion_busy_flag;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("Completion did not lower irq or clear busy.");

  property p_watch_holdoff;
    @(posedge clock) disable iff (sys_rst)
      $rose(pen_bias_en) && $past(q_reg.st) == S_WAIT_TICK && q_reg.mode == MODE_PEN_WATCH && !$past(cmd_valid)
      |-> $past(irq_n);
  endproperty
  a_watch_holdoff: assert property (p_watch_holdoff) else $error("Pen detection ran with irq low.");

  property p_trigger_unread;
    @(posedge clock) disable iff (sys_rst)
      $rose(pen_bias_en) && $past(q_reg.st) == S_WAIT_TICK && q_reg.mode == MODE_PEN_TRIGGER
      && !$past(cmd_valid) |-> $past(q_reg.unread) == '0;
  endproperty
  a_trigger_unread: assert property (p_trigger_unread) else $error("Tick served with unread data.");

  property p_overhead_len;
    @(posedge clock) disable iff (sys_rst)
      $rose(conversion_busy_flag) && q_reg.pend != '0 |-> ##47 (q_reg.st == S_CH_BIAS || !conversion_busy_flag);
  endproperty
  a_overhead_len: assert property (p_overhead_len) else $error("Overhead not 47 cycles.");

  property p_biased_convert;
    @(posedge clock) disable iff (sys_rst)
      adc_start |-> ch_bias == (NCHAN'(1) << adc_channel);
  endproperty
  a_biased_convert: assert property (p_biased_convert) else $error("Conversion on unbiased channel.");

  property p_bias_release;
    @(posedge clock) disable iff (sys_rst)
      q_reg.st == S_SAMPLE && q_reg.cnt == '0 && q_reg.left == 3'h0 && !cmd_valid |=> ch_bias == '0 && result_valid == 1'b0;
  endproperty
  a_bias_release: assert property (p_bias_release) else $error("Bias not removed after last sample.");

  property p_sample_spacing;
    @(posedge clock) disable iff (sys_rst)
      adc_start |=> (!adc_start)[*8];
  endproperty
  a_sample_spacing: assert property (p_sample_spacing) else $error("Conversions too close together.");

endmodule : tas_acquisition_sequencer

// [hdl/tas_pkg.sv]
// Constants and enumerations shared by the touch acquisition sequencer and its sample filter.
// Assumes a single 10 MHz clock that also serves as the converter's oscillator period.
package tas_pkg;

  // Clock and delay timing.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int HALF_US_NS       = 500;
  localparam int HALF_US_CYCLES   = (HALF_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_MAX_NS       = 18_190_000;
  localparam int DLY_MAX_UNITS    = DLY_MAX_NS / HALF_US_NS;
  localparam int DLY_W            = 18;
  localparam int TICK_UNIT_US     = 1000;
  localparam int TICK_UNIT_CYCLES = TICK_UNIT_US * 1000 / CLK_PERIOD_NS;

  // Acquisition timing in oscillator periods.
  localparam int OVERHEAD_CYCLES  = 47;
  localparam int SAMPLE_CYCLES    = 21;
  localparam int PEN_BIAS_SHIFT   = 3;

  // Channels and samples.
  localparam int          SMP_W       = 12;
  localparam int          SUM_W       = 15;
  localparam int          NCHAN       = 5;
  localparam int          CH_W        = 3;
  localparam logic [2:0]  SEQ_ALL_SEL = 3'h7;

  // Filter order codes and output scaling.
  localparam logic [1:0]  FILT_NONE    = 2'h0;
  localparam logic [1:0]  FILT_MEAN3   = 2'h1;
  localparam logic [1:0]  FILT_MEAN5   = 2'h2;
  localparam logic [1:0]  FILT_MEDIAN7 = 2'h3;
  localparam int          SCALE_NUM    = 4079;
  localparam int          SCALE_DEN    = 4095;
  localparam logic [11:0] SCALE_MAX    = 12'hFEF;

  // Interrupt source bit positions and reset values.
  localparam int          IRQ_W       = 3;
  localparam int          IRQ_CONV    = 0;
  localparam int          IRQ_TOUCH   = 1;
  localparam int          IRQ_RELEASE = 2;
  localparam logic [2:0]  RST_IRQ_SRC = 3'h0;

  typedef enum logic [1:0] {
    MODE_MANUAL,
    MODE_PEN_WATCH,
    MODE_PEN_TRIGGER
  } tas_mode_e;

  typedef enum logic [2:0] {
    CMD_MANUAL,
    CMD_PEN_WATCH,
    CMD_PEN_TRIGGER,
    CMD_SELECT,
    CMD_CONVERT
  } tas_cmd_e;

endpackage : tas_pkg

// [hdl/tas_sample_filter.sv]
// Sample filter of the touch acquisition sequencer: pass-through, mean of 3 or 5, or median-7 mean.
// Assumes samples of one channel arrive between a clear pulse and a finish pulse, all on one clock.
`timescale 1ns/1ns
module tas_sample_filter
  import tas_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Sample stream
  input  wire logic [1:0]       order,
  input  wire logic             clear,
  input  wire logic             sample_valid,
  input  wire logic [SMP_W-1:0] sample_data,
  input  wire logic             finish,
  // Filtered result
  output logic                  out_valid,
  output logic [SMP_W-1:0]      out_data
);

  typedef struct packed {
    logic [1:0]       order;
    logic [SUM_W-1:0] sum;
    logic [SMP_W-1:0] max1;
    logic [SMP_W-1:0] max2;
    logic [SMP_W-1:0] min1;
    logic [SMP_W-1:0] min2;
    logic             out_valid;
    logic [SMP_W-1:0] out_data;
  } tas_filt_s;

  tas_filt_s q_reg;
  tas_filt_s q_next;

  logic [SUM_W-1:0] num;
  logic [26:0]      prod;

  // Keeping only the two extremes on each side avoids a full seven-sample sort network.
  always_comb begin
    q_next = q_reg;
    q_next.out_valid = 1'b0;
    num = q_reg.sum;
    if (q_reg.order == FILT_MEDIAN7) begin
      num = q_reg.sum - SUM_W'(q_reg.max1) - SUM_W'(q_reg.max2) - SUM_W'(q_reg.min1) - SUM_W'(q_reg.min2);
    end
    prod = 27'(num) * 27'(SCALE_NUM);
    if (clear) begin
      q_next.order = order;
      q_next.sum = '0;
      q_next.max1 = '0;
      q_next.max2 = '0;
      q_next.min1 = '1;
      q_next.min2 = '1;
    end else if (sample_valid) begin
      q_next.sum = q_reg.sum + SUM_W'(sample_data);
      if (sample_data >= q_reg.max1) begin
        q_next.max1 = sample_data;
        q_next.max2 = q_reg.max1;
      end else if (sample_data > q_reg.max2) begin
        q_next.max2 = sample_data;
      end
      if (sample_data <= q_reg.min1) begin
        q_next.min1 = sample_data;
        q_next.min2 = q_reg.min1;
      end else if (sample_data < q_reg.min2) begin
        q_next.min2 = sample_data;
      end
    end
    if (finish) begin
      q_next.out_valid = 1'b1;
      unique case (q_reg.order)
        FILT_NONE:  q_next.out_data = q_reg.sum[SMP_W-1:0];
        FILT_MEAN5: q_next.out_data = SMP_W'(prod / 27'(5 * SCALE_DEN));
        FILT_MEAN3,
        FILT_MEDIAN7: q_next.out_data = SMP_W'(prod / 27'(3 * SCALE_DEN));
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q_reg <= '{order: FILT_NONE, sum: '0, max1: '0, max2: '0, min1: '1, min2: '1,
                 out_valid: 1'b0, out_data: '0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign out_valid = q_reg.out_valid;
  assign out_data  = q_reg.out_data;

  property p_scaled_range;
    @(posedge clock) disable iff (sys_rst)
      out_valid && q_reg.order != FILT_NONE |-> out_data <= SCALE_MAX;
  endproperty
  a_scaled_range: assert property (p_scaled_range) else $error("Scaled mean above full-scale bound.");

  property p_median_order;
    @(posedge clock) disable iff (sys_rst)
      finish && q_reg.order == FILT_MEDIAN7 |-> q_reg.max1 >= q_reg.max2 && q_reg.min1 <= q_reg.min2;
  endproperty
  a_median_order: assert property (p_median_order) else $error("Median extremes out of order.");

endmodule : tas_sample_filter

// [testbench/tas_analog_model.sv]
// Converter model: each start pulse yields salt plus a fixed step times the start count.
// Assumes the sequencer samples the code within 21 cycles of its start pulse.
`timescale 1ns/1ns
module tas_analog_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Converter
  input  wire logic        adc_start,
  input  wire logic [11:0] salt,
  output logic      [11:0] adc_data
);
  int nsmp;
  int hold;
  // Outside the hold window the code toggles, so a stale sample never passes.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      nsmp <= 0;
      hold <= 0;
      adc_data <= 12'h0;
    end else if (adc_start) begin
      adc_data <= salt + 12'(nsmp) * 12'h29B;
      nsmp <= nsmp + 1;
      hold <= 21;
    end else if (hold > 0) hold <= hold - 1;
    else adc_data <= ~adc_data;
  end
endmodule : tas_analog_model

// [testbench/touch_acquisition_sequencer_tb_top.sv]
// Bench of the acquisition sequencer: filters, manual, pen-watch and pen-trigger modes.
// Assumes the converter model's code sequence; expected results wait in a queue.
`timescale 1ns/1ns
module touch_acquisition_sequencer_tb_top;
  import tas_pkg::*;
  logic clock = 1'h0, sys_rst = 1'h1, cmd_valid = 1'h0, data_read = 1'h0, irq_source_read = 1'h0, pen_comparator = 1'h0;
  tas_cmd_e cmd_code = CMD_MANUAL;
  logic [2:0] cmd_channel = 3'h0, data_read_channel = 3'h0, interrupt_mask = 3'h7, result_channel, interrupt_source;
  logic [7:0] touch_tick_rate = 8'h0;
  logic [1:0] filter_order = 2'h0;
  logic [15:0] bias_delay = 16'h1, inter_sample_delay = 16'h1;
  logic [4:0] channel_enable_mask = 5'h0, ch_bias;
  logic [11:0] salt = 12'h0, adc_data, result_data;
  logic adc_start, result_valid, conversion_busy_flag, pen_down_flag, irq_n, pen_bias_en;
  logic [2:0] adc_channel;
  int errors = 0, n_tests = 0, seed = 4833, nsmp = 0, cy;
  logic [14:0] expq[$];
  tas_acquisition_sequencer #(.TICK_UNIT(10)) tas_acquisition_sequencer_inst (.clock, .sys_rst, .cmd_valid,
    .cmd_code, .cmd_channel, .touch_tick_rate, .filter_order, .bias_delay, .inter_sample_delay, .channel_enable_mask,
    .interrupt_mask, .data_read, .data_read_channel, .irq_source_read, .pen_comparator, .ch_bias, .pen_bias_en,
    .adc_start, .adc_channel, .adc_data, .result_valid, .result_channel, .result_data, .conversion_busy_flag,
    .pen_down_flag, .interrupt_source, .irq_n);
  tas_analog_model tas_analog_model_inst (.clock, .sys_rst, .adc_start, .salt, .adc_data);
  always #50 clock = ~clock;
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(string nm, logic [14:0] exp, logic [14:0] got);
    n_tests++;
    if (exp !== got) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic until_ok(bit ok, string nm);
    if (!ok) begin
      errors++;
      $display("MISMATCH %s expected 1 seen 0", nm);
      complete_run();
    end
  endtask : until_ok
  task automatic cmd(tas_cmd_e c, logic [2:0] ch);
    @(posedge clock);
    cmd_valid <= 1'h1;
    cmd_code <= c;
    cmd_channel <= ch;
    @(posedge clock);
    cmd_valid <= 1'h0;
  endtask : cmd
  task automatic rd(logic [2:0] ch, bit src);
    @(posedge clock);
    data_read <= !src;
    irq_source_read <= src;
    data_read_channel <= ch;
    @(posedge clock);
    data_read <= 1'h0;
    irq_source_read <= 1'h0;
  endtask : rd
  // Mirrors the converter model's code sequence and applies the filter arithmetic.
  function automatic void expect_ch(logic [2:0] ch);
    logic [11:0] s[$], t;
    int n = 2 * filter_order + 1, sum = 0, lo = 0, cnt;
    for (int k = 0; k < n; k++) s.push_back(salt + 12'(nsmp + k) * 12'h29B);
    nsmp += n;
    for (int i = 1; i < n; i++) begin
      for (int j = i; j > 0 && s[j - 1] > s[j]; j--) begin
        t = s[j];
        s[j] = s[j - 1];
        s[j - 1] = t;
      end
    end
    if (n == 7) lo = 2;
    cnt = (n == 7) ? 3 : n;
    for (int k = lo; k < lo + cnt; k++) sum += s[k];
    expq.push_back({ch, 12'(n == 1 ? sum : sum * 4079 / (cnt * 4095))});
  endfunction : expect_ch
  always @(posedge clock) if (result_valid) begin
    if (expq.size() == 0) chk("extra result", 15'h0, {result_channel, result_data});
    else chk("result", expq.pop_front(), {result_channel, result_data});
  end
  initial begin
    salt = 12'($random(seed));
    repeat (10) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
    @(posedge clock);
    chk("reset", 15'h1, {pen_down_flag, conversion_busy_flag, interrupt_source, ch_bias, irq_n});
    for (int o = 0; o < 4; o++) begin
      filter_order <= 2'(o);
      bias_delay <= 16'(($random(seed) & 3) + 1);
      inter_sample_delay <= 16'(($random(seed) & 3) + 1);
      interrupt_mask <= (o == 3) ? 3'h6 : 3'h7;
      cmd(CMD_SELECT, 3'(o));
      @(posedge clock);
      chk("select bias", 15'({3'(o), 1'h0, 5'(1 << o)}), 15'({adc_channel, pen_bias_en, ch_bias}));
      expect_ch(3'(o));
      cmd(CMD_CONVERT, 3'(o));
      cy = 0;
      for (int t = 0; t < 5000 && (cy == 0 || conversion_busy_flag); t++) begin
        @(posedge clock);
        cy += conversion_busy_flag;
      end
      until_ok(cy != 0 && !conversion_busy_flag, "busy end");
      chk("busy cycles", 15'(49 + 5 * bias_delay + 10 * o * inter_sample_delay + 21 * (2 * o + 1)),
          15'(cy));
      chk("irq done", 15'(o == 3), 15'(irq_n));
      rd(3'(o), 1'h0);
      @(posedge clock);
      chk("irq read", 15'h1, 15'(irq_n));
    end
    $display("filter test done");
    channel_enable_mask <= 5'($random(seed)) | 5'h1;
    filter_order <= 2'h0;
    pen_comparator <= 1'h1;
    @(posedge clock);
    for (int c = 0; c < NCHAN; c++) if (channel_enable_mask[c]) expect_ch(3'(c));
    cmd(CMD_CONVERT, SEQ_ALL_SEL);
    for (cy = 0; cy < 3000 && expq.size() > 0; cy++) @(posedge clock);
    until_ok(expq.size() == 0, "sequence");
    repeat (3) @(posedge clock);
    chk("bias off", 15'h0, {pen_down_flag, ch_bias});
    for (int c = 0; c < NCHAN; c++) if (channel_enable_mask[c]) rd(3'(c), 1'h0);
    pen_comparator <= 1'h0;
    cmd(CMD_CONVERT, 3'h2);
    repeat (300) @(posedge clock);
    $display("manual test done");
    touch_tick_rate <= 8'h3;
    cmd(CMD_PEN_WATCH, 3'h0);
    @(posedge clock);
    chk("pen bias", 15'h1, 15'(pen_bias_en));
    repeat (19) @(posedge clock);
    pen_comparator <= 1'h1;
    for (cy = 0; cy < 600 && !pen_down_flag; cy++) @(posedge clock);
    until_ok(pen_down_flag, "touch");
    repeat (2) @(posedge clock);
    chk("touch", 15'h4, {interrupt_source, irq_n});
    pen_comparator <= 1'h0;
    repeat (200) @(posedge clock);
    chk("held off", 15'h1, 15'(pen_down_flag));
    rd(3'h0, 1'h1);
    for (cy = 0; cy < 600 && pen_down_flag; cy++) @(posedge clock);
    until_ok(!pen_down_flag, "release");
    repeat (2) @(posedge clock);
    chk("release", 15'h8, {interrupt_source, irq_n});
    rd(3'h0, 1'h1);
    cmd(CMD_MANUAL, 3'h0);
    touch_tick_rate <= 8'h0;
    @(posedge clock);
    touch_tick_rate <= 8'h2;
    channel_enable_mask <= 5'h3;
    expect_ch(3'h0);
    expect_ch(3'h1);
    cmd(CMD_PEN_TRIGGER, 3'h0);
    pen_comparator <= 1'h1;
    repeat (600) @(posedge clock);
    chk("trigger", 15'h3, {12'(expq.size()), interrupt_source});
    expect_ch(3'h0);
    expect_ch(3'h1);
    rd(3'h0, 1'h0);
    rd(3'h1, 1'h0);
    repeat (600) @(posedge clock);
    chk("next round", 15'h0, 15'(expq.size()));
    cmd(CMD_MANUAL, 3'h0);
    $display("pen mode test done");
    complete_run();
  end
endmodule : touch_acquisition_sequencer_tb_top
